/* sabc_pkg.sv */
package sabc_pkg;
	// register indices; the byte address on the bus is four times the index
	localparam logic [15:0] IDX_READY = 16'hf60f;
	localparam logic [15:0] IDX_CS_L = 16'hf610;
	localparam logic [15:0] IDX_CS_R = 16'hf620;
	localparam logic [15:0] IDX_UD_L = 16'hf630;
	localparam logic [15:0] IDX_UD_R = 16'hf640;
	localparam logic [15:0] IDX_VB_L = 16'hf650;
	localparam logic [15:0] IDX_VB_R = 16'hf660;
	localparam logic [15:0] IDX_PB_L = 16'hf670;
	localparam logic [15:0] IDX_PB_R = 16'hf680;
	localparam logic [15:0] IDX_TX_ON = 16'hf690;
	localparam logic [15:0] IDX_PWR = 16'hf051;
	localparam logic [15:0] IDX_IRQ_STAT = 16'hf6f0;
	localparam logic [15:0] IDX_IRQ_EN = 16'hf6f1;
	localparam logic [15:0] IDX_IRQ_CLR = 16'hf6f2;
	localparam int WORDS = 12;
	localparam int FRAMES = 192;
	localparam int FIDX_W = 8;
	localparam int PWR_TX_BIT = 2;
	localparam logic [15:0] PWR_RESET = 16'h0004;
	localparam logic [7:0] LAST_FRAME = 8'hbf;
	localparam logic [31:0] UNMAPPED_DATA = 32'h0000_0000;
	// interrupt status bits
	localparam int EV_BLOCK = 0;
	localparam int EV_OVERRUN = 1;
	localparam int EV_W = 2;
	typedef enum logic [0:0] {
		SABC_IDLE = 1'b0,
		SABC_RESP = 1'b1
	} sabc_bus_t;
endpackage : sabc_pkg

/* sabc_capture.sv */
// Local design decision: the Avalon-MM slave port.
`timescale 1ns/1ps
// Summary of operation
// - bit 0 of the ready register reads 1 when a full captured block is available.
// - ready rises only after all 192 frames of a block arrived, one per frame.
// - twelve read-only words at 0xF610 hold left channel status bits, reset zero.
// - twelve read-only words at 0xF620 hold right channel status bits, reset zero.
// - twelve read-only words at 0xF630 hold left user data bits, reset zero.
// - twelve read-only words at 0xF640 hold right user data bits, reset zero.
// - twelve read-only words at 0xF650 hold left validity bits, reset zero.
// - twelve read-only words 0xF660 to 0xF66B hold right validity bits, reset zero.
// - twelve read-only words at 0xF670 hold left parity bits, reset zero.
// - twelve read-only words at 0xF680 hold right parity bits, reset zero.
// - output-enable is bit 0 of read-write register 0xF690, resets to 0.
// - with output-enable clear the transmitter keeps running and sends zero audio.
// - transmitter power is bit 2 of register 0xF051, zero powers it off.
module sabc_capture #(
	parameter int AUDIO_W = 24
) (
	input wire logic clk,
	input wire logic rst,
	// avalon-mm slave, word addressed by byte address
	input wire logic [17:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	output logic [1:0] avs_response,
	// decoded receiver frames, one strobe per frame
	input wire logic rx_frame_valid,
	input wire logic rx_block_start,
	input wire logic rx_cs_left,
	input wire logic rx_cs_right,
	input wire logic rx_user_data_left,
	input wire logic rx_user_data_right,
	input wire logic rx_validity_left,
	input wire logic rx_validity_right,
	input wire logic rx_parity_left,
	input wire logic rx_parity_right,
	// transmitter audio path
	input wire logic [AUDIO_W-1:0] tx_audio_left_in,
	input wire logic [AUDIO_W-1:0] tx_audio_right_in,
	output logic [AUDIO_W-1:0] tx_audio_left,
	output logic [AUDIO_W-1:0] tx_audio_right,
	output logic tx_output_on,
	output logic tx_power_on,
	output logic irq
);
	import sabc_pkg::*;

	localparam int GROUPS = 8;
	localparam int BITS = WORDS * 16;

	logic [BITS-1:0] shadow_q [GROUPS];
	logic [BITS-1:0] cap_q [GROUPS];
	logic [GROUPS-1:0] rx_bits;
	logic [FIDX_W-1:0] frame_q;
	logic ready_q;
	logic tx_on_q;
	logic [15:0] pwr_q;
	logic [EV_W-1:0] irq_stat_q;
	logic [EV_W-1:0] irq_en_q;
	sabc_bus_t bus_q;
	logic [31:0] rdata_q;
	logic [1:0] resp_q;

	assign rx_bits = {rx_parity_right, rx_parity_left, rx_validity_right, rx_validity_left,
		rx_user_data_right, rx_user_data_left, rx_cs_right, rx_cs_left};

	// frame counter: a block_start strobe realigns to frame 0
	wire [FIDX_W-1:0] frame_now = rx_block_start ? '0 : frame_q;
	wire last_frame = rx_frame_valid && (frame_now == LAST_FRAME);
	wire [FIDX_W-1:0] frame_next = last_frame ? '0 : frame_now + 1'b1;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			frame_q <= '0;
		end else if (rx_frame_valid) begin
			frame_q <= frame_next;
		end
	end

	// shadow capture per group, then block-wide copy so readers never see two blocks
	genvar g;
	generate
		for (g = 0; g < GROUPS; g++) begin : g_grp
			always_ff @(posedge clk or posedge rst) begin
				if (rst) begin
					shadow_q[g] <= '0;
				end else if (rx_frame_valid) begin
					shadow_q[g][frame_now] <= rx_bits[g];
				end
			end
			// the last bit bypasses the shadow so the copy is whole in one edge
			always_ff @(posedge clk or posedge rst) begin
				if (rst) begin
					cap_q[g] <= '0;
				end else if (last_frame) begin
					cap_q[g] <= {rx_bits[g], shadow_q[g][BITS-2:0]};
				end
			end
		end
	endgenerate

	// bus decode
	wire [15:0] idx = avs_address[17:2];
	wire req = (avs_read || avs_write) && (bus_q == SABC_IDLE);
	wire wr_lo = avs_write && avs_byteenable[0] && req;
	wire hit_tx = (idx == IDX_TX_ON);
	wire hit_pwr = (idx == IDX_PWR);
	wire hit_en = (idx == IDX_IRQ_EN);
	wire hit_clr = (idx == IDX_IRQ_CLR);
	wire rd_ready = avs_read && req && (idx == IDX_READY);

	function automatic logic in_group(input logic [15:0] a, input logic [15:0] base);
		in_group = (a >= base) && (a < base + 16'(WORDS));
	endfunction : in_group

	// group selection
	wire [2:0] grp_sel = (idx[7:4] == IDX_CS_L[7:4]) ? 3'd0 :
		(idx[7:4] == IDX_CS_R[7:4]) ? 3'd1 :
		(idx[7:4] == IDX_UD_L[7:4]) ? 3'd2 :
		(idx[7:4] == IDX_UD_R[7:4]) ? 3'd3 :
		(idx[7:4] == IDX_VB_L[7:4]) ? 3'd4 :
		(idx[7:4] == IDX_VB_R[7:4]) ? 3'd5 :
		(idx[7:4] == IDX_PB_L[7:4]) ? 3'd6 : 3'd7;
	wire hit_words = in_group(idx, IDX_CS_L) || in_group(idx, IDX_CS_R) || in_group(idx, IDX_UD_L) ||
		in_group(idx, IDX_UD_R) || in_group(idx, IDX_VB_L) || in_group(idx, IDX_VB_R) ||
		in_group(idx, IDX_PB_L) || in_group(idx, IDX_PB_R);
	wire [3:0] word_sel = idx[3:0];
	wire [15:0] word_val = cap_q[grp_sel][{word_sel, 4'h0} +: 16];

	// read mux as an if chain
	logic [31:0] rmux;
	logic rhit;
	always_comb begin
		rmux = UNMAPPED_DATA;
		rhit = 1'b1;
		if (idx == IDX_READY) begin
			rmux = {31'h0, ready_q};
		end else if (hit_words) begin
			rmux = {16'h0, word_val};
		end else if (hit_tx) begin
			rmux = {31'h0, tx_on_q};
		end else if (hit_pwr) begin
			rmux = {16'h0, pwr_q};
		end else if (idx == IDX_IRQ_STAT) begin
			rmux = {30'h0, irq_stat_q};
		end else if (hit_en) begin
			rmux = {30'h0, irq_en_q};
		end else if (hit_clr) begin
			rmux = UNMAPPED_DATA;
		end else begin
			rhit = 1'b0;
		end
	end

	// one wait cycle, answer on the second edge; unmapped gives slave error
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			bus_q <= SABC_IDLE;
			rdata_q <= '0;
			resp_q <= 2'b00;
		end else if (bus_q == SABC_IDLE) begin
			bus_q <= (avs_read || avs_write) ? SABC_RESP : SABC_IDLE;
			rdata_q <= avs_read ? rmux : '0;
			resp_q <= rhit ? 2'b00 : 2'b10;
		end else begin
			bus_q <= SABC_IDLE;
		end
	end
	assign avs_waitrequest = (avs_read || avs_write) && (bus_q == SABC_IDLE);
	assign avs_readdata = rdata_q;
	assign avs_response = resp_q;

	// ready is set by a completed block; reading it clears it, set wins
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ready_q <= 1'b0;
		end else if (last_frame) begin
			ready_q <= 1'b1;
		end else if (rd_ready) begin
			ready_q <= 1'b0;
		end
	end

	// control registers
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			tx_on_q <= 1'b0;
			pwr_q <= PWR_RESET;
			irq_en_q <= '0;
		end else if (wr_lo) begin
			if (hit_tx) tx_on_q <= avs_writedata[0];
			if (hit_pwr) pwr_q <= avs_writedata[15:0];
			if (hit_en) irq_en_q <= avs_writedata[EV_W-1:0];
		end
	end

	// sticky events: block done, and block done while the previous was unread
	wire [EV_W-1:0] ev = {last_frame && ready_q && !rd_ready, last_frame};
	wire [EV_W-1:0] clr = (wr_lo && hit_clr) ? avs_writedata[EV_W-1:0] : '0;
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			irq_stat_q <= '0;
		end else begin
			irq_stat_q <= (irq_stat_q & ~clr) | ev; // set wins over clear
		end
	end
	assign irq = |(irq_stat_q & irq_en_q);

	// transmitter keeps streaming; disabled means zero audio, not silence of the line
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			tx_audio_left <= '0;
			tx_audio_right <= '0;
		end else begin
			tx_audio_left <= tx_on_q ? tx_audio_left_in : '0;
			tx_audio_right <= tx_on_q ? tx_audio_right_in : '0;
		end
	end
	assign tx_output_on = tx_on_q;
	assign tx_power_on = pwr_q[PWR_TX_BIT];

	// checks
	a_ready_after_block: assert property (@(posedge clk) disable iff (rst)
		last_frame |=> ready_q) else $error("ready did not rise after last frame");
	a_ready_cause: assert property (@(posedge clk) disable iff (rst)
		$rose(ready_q) |-> $past(last_frame)) else $error("ready rose without a full block");
	a_frame_count: assert property (@(posedge clk) disable iff (rst)
		frame_q < 8'(FRAMES)) else $error("frame counter out of range");
	a_words_hold: assert property (@(posedge clk) disable iff (rst)
		!$past(last_frame) |-> $stable(cap_q[0]) && $stable(cap_q[7])) else $error("words changed mid block");
	a_words_load: assert property (@(posedge clk) disable iff (rst)
		last_frame |=> cap_q[1][BITS-1] == $past(rx_cs_right)) else $error("last frame bit not loaded");
	a_tx_zero: assert property (@(posedge clk) disable iff (rst)
		!tx_on_q ##1 !tx_on_q |-> tx_audio_left == '0 && tx_audio_right == '0) else $error("audio not zero");
	a_tx_write: assert property (@(posedge clk) disable iff (rst)
		wr_lo && hit_tx |=> tx_on_q == $past(avs_writedata[0])) else $error("enable write lost");
	a_pwr_bit: assert property (@(posedge clk) disable iff (rst)
		wr_lo && hit_pwr |=> tx_power_on == $past(avs_writedata[PWR_TX_BIT])) else $error("power bit wrong");
	// a request is taken in the idle state; the answer follows one cycle later
	sequence s_bus_taken;
		(avs_read || avs_write) && bus_q == SABC_IDLE;
	endsequence
	a_bus_answer: assert property (@(posedge clk) disable iff (rst)
		s_bus_taken |=> !avs_waitrequest) else $error("no answer in one cycle");
endmodule : sabc_capture

/* sabc_src.sv */
`timescale 1ns/1ps
// receiver front end: one decoded frame per strobe, 192 frames to a block
module sabc_src #(
	parameter int GAP = 3
) (
	input wire logic clk,
	input wire logic go,
	output logic rx_frame_valid,
	output logic rx_block_start,
	output logic [7:0] bits,
	output logic done
);
	// bit order: cs, user data, validity, parity; left then right for each
	function automatic logic [7:0] frame_bits(input int n);
		return {n[0] ^ n[3], n[6:0]};
	endfunction : frame_bits
	// GAP of one or more keeps each strobe a single-cycle pulse
	initial begin
		rx_frame_valid = 1'b0;
		rx_block_start = 1'b0;
		bits = 8'h00;
		done = 1'b0;
		forever begin
			@(posedge clk);
			if (go) begin
				done <= 1'b0;
				for (int n = 0; n < 192; n++) begin
					rx_frame_valid <= 1'b1;
					rx_block_start <= (n == 0);
					bits <= frame_bits(n);
					@(posedge clk);
					rx_frame_valid <= 1'b0;
					rx_block_start <= 1'b0; // block start only qualifies a frame strobe
					bits <= ~bits; // idle lines never keep the last bit
					repeat (GAP) @(posedge clk);
				end
				done <= 1'b1;
			end
		end
	end
endmodule : sabc_src

/* sabc_capture_bench.sv */
`timescale 1ns/1ps
module sabc_capture_bench;
	import sabc_pkg::*;
	logic clk, rst, avs_read, avs_write, avs_waitrequest, go, done;
	logic [17:0] avs_address;
	logic [31:0] avs_writedata, avs_readdata, rd;
	logic [1:0] avs_response, rs;
	logic [3:0] avs_byteenable;
	logic rx_frame_valid, rx_block_start, tx_output_on, tx_power_on, irq;
	logic [7:0] bits;
	logic [23:0] tx_audio_left, tx_audio_right;
	int bad_count = 0;
	int compares = 0;
	logic [15:0] bases [8] = '{IDX_CS_L, IDX_CS_R, IDX_UD_L, IDX_UD_R, IDX_VB_L, IDX_VB_R, IDX_PB_L, IDX_PB_R};
	sabc_capture u_dut (.clk(clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
		.avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .avs_response(avs_response), .rx_frame_valid(rx_frame_valid),
		.rx_block_start(rx_block_start), .rx_cs_left(bits[0]), .rx_cs_right(bits[1]),
		.rx_user_data_left(bits[2]), .rx_user_data_right(bits[3]), .rx_validity_left(bits[4]),
		.rx_validity_right(bits[5]), .rx_parity_left(bits[6]), .rx_parity_right(bits[7]),
		.tx_audio_left_in(24'h123456), .tx_audio_right_in(24'habcdef), .tx_audio_left(tx_audio_left),
		.tx_audio_right(tx_audio_right), .tx_output_on(tx_output_on), .tx_power_on(tx_power_on), .irq(irq));
	sabc_src u_src (.clk(clk), .go(go), .rx_frame_valid(rx_frame_valid), .rx_block_start(rx_block_start),
		.bits(bits), .done(done));
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			bad_count++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk
	// request held until waitrequest is sampled low, then one idle cycle
	task automatic bus(input logic wr, input logic [15:0] idx, input logic [31:0] wd);
		int n;
		n = 0;
		avs_address <= {idx, 2'b00};
		avs_write <= wr;
		avs_read <= !wr;
		avs_writedata <= wd;
		do begin
			@(posedge clk);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 100);
		if (avs_waitrequest !== 1'b0)
			bad_count++;
		rd = avs_readdata;
		rs = avs_response;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		@(posedge clk);
	endtask : bus
	task automatic rdchk(input string what, input logic [15:0] idx, input logic [31:0] exp);
		bus(1'b0, idx, 32'h0);
		chk(what, rd, exp);
	endtask : rdchk
	// frame n lands in word n/16, bit n%16
	function automatic logic [31:0] exp_word(input int g, input int w);
		logic [31:0] v;
		int n;
		v = 32'h0;
		for (int b = 0; b < 16; b++) begin
			n = w * 16 + b;
			v[b] = (g == 7) ? n[0] ^ n[3] : n[g];
		end
		return v;
	endfunction : exp_word
	// mid reads ready early in the block; a read clears ready, so overrun runs skip it
	task automatic run_block(input logic mid);
		int n;
		go <= 1'b1;
		@(posedge clk);
		go <= 1'b0;
		@(posedge clk);
		if (mid)
			rdchk("ready mid", IDX_READY, 32'h0);
		n = 0;
		while (done !== 1'b1 && n < 2000) begin
			@(posedge clk);
			n++;
		end
		if (done !== 1'b1)
			bad_count++;
	endtask : run_block
	task automatic finish_test();
		$display("TB: compares %0d mismatches %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : finish_test
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	// watchdog: the run needs about 2700 cycles
	initial begin
		repeat (20000) @(posedge clk);
		bad_count++;
		finish_test();
	end
	initial begin
		rst = 1'b1;
		go = 1'b0;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_address = 18'h0;
		avs_writedata = 32'h0;
		avs_byteenable = 4'hf;
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		for (int g = 0; g < 8; g++)
			rdchk("word reset", bases[g] + 16'h000b, 32'h0);
		rdchk("ready reset", IDX_READY, 32'h0);
		rdchk("tx on reset", IDX_TX_ON, 32'h0);
		rdchk("power reset", IDX_PWR, {16'h0, PWR_RESET});
		bus(1'b1, IDX_CS_L, 32'hffff);
		rdchk("ro write", IDX_CS_L, 32'h0);
		bus(1'b0, 16'hf66c, 32'h0);
		chk("past last word", {30'h0, rs}, 32'h2);
		$display("TB: reset test done");
		chk("audio muted", {8'h0, tx_audio_left}, 32'h0);
		bus(1'b1, IDX_TX_ON, 32'h1);
		rdchk("tx on", IDX_TX_ON, 32'h1);
		chk("audio on", {8'h0, tx_audio_right}, 32'habcdef);
		chk("audio left on", {8'h0, tx_audio_left}, 32'h123456);
		avs_byteenable <= 4'he;
		bus(1'b1, IDX_TX_ON, 32'h0);
		avs_byteenable <= 4'hf;
		rdchk("low lane off", IDX_TX_ON, 32'h1);
		bus(1'b1, IDX_PWR, 32'h0);
		chk("power gate", {30'h0, tx_power_on, tx_output_on}, 32'h1);
		bus(1'b1, IDX_TX_ON, 32'h0);
		chk("audio muted again", {8'h0, tx_audio_right}, 32'h0);
		chk("output off", {31'h0, tx_output_on}, 32'h0);
		$display("TB: transmitter test done");
		bus(1'b1, IDX_IRQ_EN, 32'h1);
		run_block(1'b1);
		chk("irq raised", {31'h0, irq}, 32'h1);
		rdchk("ready set", IDX_READY, 32'h1);
		for (int g = 0; g < 8; g++)
			for (int w = 0; w < 12; w++)
				rdchk("word", bases[g] + 16'(w), exp_word(g, w));
		rdchk("ready cleared", IDX_READY, 32'h0);
		rdchk("irq status", IDX_IRQ_STAT, 32'h1);
		bus(1'b1, IDX_IRQ_CLR, 32'h1);
		chk("irq cleared", {31'h0, irq}, 32'h0);
		bus(1'b1, IDX_IRQ_EN, 32'h0);
		run_block(1'b1);
		chk("irq masked", {31'h0, irq}, 32'h0);
		bus(1'b1, IDX_IRQ_EN, 32'h1);
		chk("irq unmasked", {31'h0, irq}, 32'h1);
		run_block(1'b0);
		rdchk("overrun status", IDX_IRQ_STAT, 32'h3);
		rdchk("ready again", IDX_READY, 32'h1);
		rdchk("words again", IDX_PB_R + 16'h000b, exp_word(7, 11));
		$display("TB: block test done");
		finish_test();
	end
endmodule : sabc_capture_bench
